// [fsrr_consts.svh]
`ifndef FSRR_CONSTS_SVH
`define FSRR_CONSTS_SVH

// ==========================================================
// opcode and link framing
// ==========================================================
`define FSRR_OPC_STATUS_READ  8'hd7
`define FSRR_BIT_LAST         3'h7

// ==========================================================
// status byte one field positions
// ==========================================================
`define FSRR_B1_IDLE          7
`define FSRR_B1_MATCH         6
`define FSRR_B1_CAP_HI        5
`define FSRR_B1_CAP_LO        2
`define FSRR_B1_GUARD         1
`define FSRR_B1_PAGE          0

// ==========================================================
// status byte two field positions
// ==========================================================
`define FSRR_B2_IDLE          7
`define FSRR_B2_RSV_HI        6
`define FSRR_B2_FAULT         5
`define FSRR_B2_RSV_LO        4
`define FSRR_B2_LOCK          3
`define FSRR_B2_HOLD2         2
`define FSRR_B2_HOLD1         1
`define FSRR_B2_EHOLD         0

// ==========================================================
// reset values
// ==========================================================
`define FSRR_RST_BYTE         8'h00
`define FSRR_RST_WORD         16'h0000
`define FSRR_RST_FLAG         1'h0
`define FSRR_RST_OE_N         1'h1

`endif

// [fsrr_pkg.sv]
package fsrr_pkg;

   // =======================================================
   // link-side command states
   // =======================================================
   typedef enum logic [1:0] {
      FSRR_LK_OPCODE = 2'b00,  // shifting in the opcode
      FSRR_LK_STATUS = 2'b01,  // streaming status bytes
      FSRR_LK_IGNORE = 2'b10   // other opcode, stay quiet
   } fsrr_link_state_t;

   // =======================================================
   // core-domain state
   // =======================================================
   typedef struct packed {
      logic       match_q;     // latest compare outcome
      logic       fault_q;     // latest erase/program result
      logic [7:0] byte_one_q;  // assembled status byte one
      logic [7:0] byte_two_q;  // assembled status byte two
      logic       buf1_en_q;   // buffer 1 write permitted
      logic       buf2_en_q;   // buffer 2 write permitted
   } fsrr_core_t;

   // =======================================================
   // link-domain synchroniser state (reset by i_rst_n only)
   // =======================================================
   typedef struct packed {
      logic [15:0] s1_q;       // first stage, read by s2 only
      logic [15:0] s2_q;       // second stage
      logic [15:0] s3_q;       // third stage
      logic [15:0] val_q;      // accepted status word
   } fsrr_sync_t;

   // =======================================================
   // link-domain frame state (reset by chip select high)
   // =======================================================
   typedef struct packed {
      fsrr_link_state_t state_q;  // command phase
      logic [2:0]       cnt_q;    // bit within byte
      logic [7:0]       op_q;     // opcode shift register
      logic [7:0]       out_q;    // outgoing shift register
      logic             sel_q;    // next byte: 1 = byte two
      logic             so_q;     // serial data out
      logic             oe_n_q;   // output enable, low drives
   } fsrr_frame_t;

endpackage : fsrr_pkg

// [fsrr_status_read.sv]
`timescale 1ns/1ps
`include "fsrr_consts.svh"
module fsrr_status_read
   import fsrr_pkg::*;
#(
   // legacy density code; value is arbitrary
   parameter logic [3:0] DENSITY_CODE = 4'h5
) (
   // core clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // status sources from internal engines
   input  wire logic i_busy,
   input  wire logic i_cmp_done,
   input  wire logic i_cmp_mismatch,
   input  wire logic i_protect_en,
   input  wire logic i_page_256,
   input  wire logic i_op_end,
   input  wire logic i_op_abort,
   input  wire logic i_op_fault,
   input  wire logic i_lockdown_off,
   input  wire logic i_buf2_suspend,
   input  wire logic i_buf1_suspend,
   input  wire logic i_erase_suspend,
   // buffer write requests and permits
   input  wire logic i_buf1_wr_req,
   input  wire logic i_buf2_wr_req,
   output logic      o_buf1_wr_en,
   output logic      o_buf2_wr_en,
   // serial link
   input  wire logic i_sck,
   input  wire logic i_cs_n,
   input  wire logic i_si,
   output logic      o_so,
   output logic      o_so_oe_n
);

   // ==========================================================
   // core domain
   // ==========================================================
   fsrr_core_t core_q;  // registered core state
   fsrr_core_t core_d;  // next core state

   // status flags and byte assembly
   always_comb begin
      core_d = core_q;
      if (i_cmp_done) begin
         core_d.match_q = i_cmp_mismatch;
      end
      if (i_op_end && !i_op_abort) begin
         // fault on failure, clear on success
         core_d.fault_q = i_op_fault;
      end
      core_d.byte_one_q[`FSRR_B1_IDLE] = ~i_busy;
      core_d.byte_one_q[`FSRR_B1_MATCH] = core_d.match_q;
      core_d.byte_one_q[`FSRR_B1_CAP_HI:`FSRR_B1_CAP_LO] =
         DENSITY_CODE;
      core_d.byte_one_q[`FSRR_B1_GUARD] = i_protect_en;
      core_d.byte_one_q[`FSRR_B1_PAGE] = i_page_256;
      core_d.byte_two_q[`FSRR_B2_IDLE] = ~i_busy;
      core_d.byte_two_q[`FSRR_B2_RSV_HI] = 1'b0;
      core_d.byte_two_q[`FSRR_B2_RSV_LO] = 1'b0;
      core_d.byte_two_q[`FSRR_B2_FAULT] = core_d.fault_q;
      core_d.byte_two_q[`FSRR_B2_LOCK] = ~i_lockdown_off;
      core_d.byte_two_q[`FSRR_B2_HOLD2] = i_buf2_suspend;
      core_d.byte_two_q[`FSRR_B2_HOLD1] = i_buf1_suspend;
      core_d.byte_two_q[`FSRR_B2_EHOLD] = i_erase_suspend;
      core_d.buf1_en_q = i_buf1_wr_req & ~i_buf1_suspend;
      core_d.buf2_en_q = i_buf2_wr_req & ~i_buf2_suspend;
   end

   // core register
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         core_q <= '{match_q:    `FSRR_RST_FLAG,
                     fault_q:    `FSRR_RST_FLAG,
                     byte_one_q: `FSRR_RST_BYTE,
                     byte_two_q: `FSRR_RST_BYTE,
                     buf1_en_q:  `FSRR_RST_FLAG,
                     buf2_en_q:  `FSRR_RST_FLAG};
      end else begin
         core_q <= core_d;
      end
   end

   assign o_buf1_wr_en = core_q.buf1_en_q;
   assign o_buf2_wr_en = core_q.buf2_en_q;

   // ==========================================================
   // crossing into the serial clock domain
   // ==========================================================
   fsrr_sync_t sync_q;  // synchroniser chain
   fsrr_sync_t sync_d;  // its next value

   // three stages; a bit is accepted once stages two and three
   // agree, which rejects a one-edge glitch on any bit but not a word caught mid-change.
   // the serial clock idles between frames, so the chain is
   // refilled during the eight opcode edges of every frame.
   always_comb begin
      sync_d       = sync_q;
      sync_d.s1_q  = {core_q.byte_two_q, core_q.byte_one_q};
      sync_d.s2_q  = sync_q.s1_q;
      sync_d.s3_q  = sync_q.s2_q;
      sync_d.val_q = (sync_q.s2_q & sync_q.s3_q) |
                     (sync_q.val_q & (sync_q.s2_q | sync_q.s3_q));
   end

   // synchroniser register
   always_ff @(posedge i_sck or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_q <= '{s1_q:  `FSRR_RST_WORD,
                     s2_q:  `FSRR_RST_WORD,
                     s3_q:  `FSRR_RST_WORD,
                     val_q: `FSRR_RST_WORD};
      end else begin
         sync_q <= sync_d;
      end
   end

   // ==========================================================
   // link frame logic
   // ==========================================================
   fsrr_frame_t frame_q;     // registered frame state
   fsrr_frame_t frame_d;     // next frame state
   logic        frame_rst;   // chip select high or reset
   logic [7:0]  opcode_now;  // opcode including current bit
   logic [7:0]  next_byte;   // byte to load next

   assign frame_rst = i_cs_n | ~i_rst_n;

   // shift opcode in, status out; updates on rising edges
   always_comb begin
      frame_d    = frame_q;
      opcode_now = {frame_q.op_q[6:0], i_si};
      next_byte  = frame_q.sel_q ? sync_q.val_q[15:8]
                                 : sync_q.val_q[7:0];
      frame_d.cnt_q = frame_q.cnt_q + 3'h1;
      case (frame_q.state_q)
         // collecting the eight opcode bits
         FSRR_LK_OPCODE: begin
            frame_d.op_q = opcode_now;
            if (frame_q.cnt_q == `FSRR_BIT_LAST) begin
               if (opcode_now == `FSRR_OPC_STATUS_READ) begin
                  frame_d.state_q = FSRR_LK_STATUS;
                  frame_d.so_q    = sync_q.val_q[7];
                  frame_d.out_q   = {sync_q.val_q[6:0], 1'b0};
                  frame_d.sel_q   = 1'b1;
                  frame_d.oe_n_q  = 1'b0;
               end else begin
                  frame_d.state_q = FSRR_LK_IGNORE;
               end
            end
         end
         // streaming, msb first
         FSRR_LK_STATUS: begin
            if (frame_q.cnt_q == `FSRR_BIT_LAST) begin
               frame_d.so_q  = next_byte[7];
               frame_d.out_q = {next_byte[6:0], 1'b0};
               frame_d.sel_q = ~frame_q.sel_q;
            end else begin
               frame_d.so_q  = frame_q.out_q[7];
               frame_d.out_q = {frame_q.out_q[6:0], 1'b0};
            end
         end
         // foreign opcode: hold quiet until deselect
         FSRR_LK_IGNORE: begin
            frame_d.cnt_q = frame_q.cnt_q;
         end
         default: begin
            frame_d.state_q = FSRR_LK_IGNORE;
         end
      endcase
   end

   // frame register; deselect clears it without any edge, since
   // the serial clock may stop the moment the frame ends
   always_ff @(posedge i_sck or posedge frame_rst) begin
      if (frame_rst) begin
         frame_q <= '{state_q: FSRR_LK_OPCODE,
                      cnt_q:   3'h0,
                      op_q:    `FSRR_RST_BYTE,
                      out_q:   `FSRR_RST_BYTE,
                      sel_q:   `FSRR_RST_FLAG,
                      so_q:    `FSRR_RST_FLAG,
                      oe_n_q:  `FSRR_RST_OE_N};
      end else begin
         frame_q <= frame_d;
      end
   end

   assign o_so      = frame_q.so_q;
   assign o_so_oe_n = frame_q.oe_n_q;

endmodule : fsrr_status_read

// [fsrr_status_read_monitor.sv]
`timescale 1ns/1ps
module fsrr_status_read_monitor #(
   parameter logic [3:0] DENSITY_CODE = 4'h5
) (
   // core side
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_buf1_wr_req,
   input wire logic i_buf2_wr_req,
   input wire logic i_buf1_suspend,
   input wire logic i_buf2_suspend,
   input wire logic o_buf1_wr_en,
   input wire logic o_buf2_wr_en,
   // link side
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_si,
   input wire logic o_so,
   input wire logic o_so_oe_n
);
   // =========
   // frame tracking
   // =========
   logic [15:0] cnt_q; // edges this frame
   logic [7:0]  op_q;  // opcode, msb first
   logic [15:0] pos;   // stream index on o_so
   assign pos = cnt_q - 16'h0008;
   // cleared by deselect, as the frame logic is
   always_ff @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         cnt_q <= 16'h0000;
         op_q  <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         if (cnt_q < 16'h0008) op_q <= {op_q[6:0], i_si};
      end
   end
   // =========
   // link checks
   // =========
   a_release_idle: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_cs_n |-> o_so_oe_n && !o_so) else $error("not released");
   a_quiet_opcode: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_rst_n)
      cnt_q < 16'h0008 |-> o_so_oe_n) else $error("early drive");
   a_oe_opcode: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_rst_n)
      cnt_q >= 16'h0008 |-> o_so_oe_n == (op_q != 8'hd7))
      else $error("drive vs opcode");
   a_oe_hold: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_rst_n)
      $fell(o_so_oe_n) |-> !o_so_oe_n [*8]) else $error("drive lost");
   a_reserved_zero: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_rst_n)
      !o_so_oe_n && pos[3:0] inside {4'h9, 4'hb} |-> !o_so)
      else $error("reserved set");
   a_density_code: assert property (
      @(posedge i_sck) disable iff (i_cs_n || !i_rst_n)
      !o_so_oe_n && pos[3:0] inside {[4'h2:4'h5]}
      |-> o_so == DENSITY_CODE[3'h5 - pos[2:0]]) else $error("density");
   // =========
   // buffer permits
   // =========
   a_wr_permit: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_buf1_wr_req && !i_buf1_suspend |=> o_buf1_wr_en)
      else $error("buffer 1 refused");
   a_wr_block: assert property (
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_buf2_suspend || !i_buf2_wr_req |=> !o_buf2_wr_en)
      else $error("buffer 2 passed");
   c_wrap: cover property (@(posedge i_sck) cnt_q == 16'h0018);
   c_refused: cover property (@(posedge i_sck) cnt_q[3] && o_so_oe_n);
   c_blocked: cover property (@(posedge i_ref_clk) i_buf2_suspend);
endmodule : fsrr_status_read_monitor
bind fsrr_status_read fsrr_status_read_monitor #(
   .DENSITY_CODE(DENSITY_CODE)
) i_mon (.i_ref_clk, .i_rst_n, .i_buf1_wr_req, .i_buf2_wr_req,
   .i_buf1_suspend, .i_buf2_suspend, .o_buf1_wr_en, .o_buf2_wr_en,
   .i_sck, .i_cs_n, .i_si, .o_so, .o_so_oe_n);

// [fsrr_host_model.sv]
`timescale 1ns/1ps
module fsrr_host_model (
   // link pins
   output logic      o_sck,
   output logic      o_cs_n,
   output logic      o_si,
   input  wire logic i_so,
   input  wire logic i_so_oe_n
);
   // =========
   // one framed transfer
   // =========
   // opcode then clocks
   task automatic xfer(input logic [7:0] op, input int n,
      output logic [63:0] rx, output logic drv);
      logic b;
      b = 1'b0;
      rx = '0;
      drv = 1'b0;
      o_cs_n = 1'b0;
      // odd lead keeps link edges off the core clock edges
      #43;
      for (int k = 0; k < n + 7; k++) begin
         // filler toggles, never a stale level
         o_si = (k < 8) ? op[7 - k] : ~o_si;
         #40 o_sck = 1'b1;
         #40 o_sck = 1'b0;
         // released line reads as inverse of last bit
         b = i_so_oe_n ? ~b : i_so;
         if (k >= 7) begin
            rx = {rx[62:0], b};
            drv = drv | ~i_so_oe_n;
         end
      end
      #40 o_cs_n = 1'b1;
      #80;
   endtask : xfer
   // sck parked low between frames
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
   end
endmodule : fsrr_host_model

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
   localparam logic [3:0] DENS = 4'ha; // arbitrary code
   // =========
   // stimulus and observation
   // =========
   logic       i_ref_clk;
   logic       i_rst_n;
   logic [6:0] lv;      // busy,prot,p256,lkoff,sus2,sus1,esus
   logic [4:0] pu;      // cdone,cmis,oend,oabort,ofault
   logic [1:0] rq;      // write requests, buffer 2 high
   logic [1:0] wr;      // write permits, buffer 2 high
   logic       sck, cs_n, si, so, oe_n;
   logic       match_e; // expected compare flag
   logic       fault_e; // expected fault flag
   int         err_count = 0;
   int         total_checks = 0;
   int         cyc = 0;
   fsrr_status_read #(.DENSITY_CODE(DENS)) i_dut (
      .i_ref_clk, .i_rst_n, .i_busy(lv[6]),
      .i_cmp_done(pu[4]), .i_cmp_mismatch(pu[3]),
      .i_protect_en(lv[5]), .i_page_256(lv[4]),
      .i_op_end(pu[2]), .i_op_abort(pu[1]), .i_op_fault(pu[0]),
      .i_lockdown_off(lv[3]), .i_buf2_suspend(lv[2]),
      .i_buf1_suspend(lv[1]), .i_erase_suspend(lv[0]),
      .i_buf1_wr_req(rq[0]), .i_buf2_wr_req(rq[1]),
      .o_buf1_wr_en(wr[0]), .o_buf2_wr_en(wr[1]),
      .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .o_so(so), .o_so_oe_n(oe_n));
   fsrr_host_model i_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si),
      .i_so(so), .i_so_oe_n(oe_n));
   // =========
   // helpers
   // =========
   function automatic logic [15:0] pair();
      return {~lv[6], match_e, DENS, lv[5], lv[4],
         ~lv[6], 1'b0, fault_e, 1'b0, ~lv[3], lv[2:0]};
   endfunction : pair
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic set_lv(input logic [6:0] v);
      @(posedge i_ref_clk) lv <= v;
      repeat (4) @(posedge i_ref_clk);
   endtask : set_lv
   task automatic pulse(input logic [4:0] v);
      @(posedge i_ref_clk) pu <= v;
      @(posedge i_ref_clk) pu <= 5'h00;
      repeat (4) @(posedge i_ref_clk);
   endtask : pulse
   task automatic rd_chk(input int n, input logic [63:0] e);
      logic [63:0] rx;
      logic        d;
      i_host.xfer(8'hd7, n, rx, d);
      chk(rx, e);
   endtask : rd_chk
   // =========
   // scenarios
   // =========
   task automatic t_fields();
      logic [15:0] e;
      for (int i = 0; i < 2; i++) begin
         set_lv(i ? 7'h2a : 7'h55);
         e = pair();
         rd_chk(40, {24'h0, e, e, e[15:8]});
      end
   endtask : t_fields
   task automatic t_flags();
      pulse(5'h18);
      match_e = 1'b1;
      pulse(5'h05);
      fault_e = 1'b1;
      pulse(5'h07);
      rd_chk(16, {48'h0, pair()});
      pulse(5'h10);
      match_e = 1'b0;
      pulse(5'h04);
      fault_e = 1'b0;
      rd_chk(16, {48'h0, pair()});
   endtask : t_flags
   task automatic t_poll();
      logic [63:0] rx;
      logic        d;
      set_lv(7'h40);
      fork
         i_host.xfer(8'hd7, 24, rx, d);
         #1000 lv <= 7'h00;
      join
      chk({62'h0, rx[23], rx[7]}, 64'h1);
   endtask : t_poll
   task automatic t_edges();
      logic [63:0] rx;
      logic        d;
      rd_chk(12, {52'h0, pair() >> 4});
      chk({62'h0, oe_n, so}, 64'h2);
      rd_chk(16, {48'h0, pair()});
      i_host.xfer(8'h0b, 16, rx, d);
      chk({63'h0, d}, 64'h0);
   endtask : t_edges
   task automatic t_buffers();
      @(posedge i_ref_clk) rq <= 2'b11;
      set_lv(7'h04);
      chk({62'h0, wr}, 64'h1);
      set_lv(7'h02);
      chk({62'h0, wr}, 64'h2);
      rq <= 2'b00;
   endtask : t_buffers
   task automatic finish_test();
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   // =========
   // clock, watchdog, sequence
   // =========
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   // a hang counts as a mismatch
   always @(posedge i_ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         err_count++;
         finish_test();
      end
   end
   initial begin
      i_rst_n = 1'b0;
      {lv, pu, rq, match_e, fault_e} = '0;
      repeat (16) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      t_fields();
      t_flags();
      t_poll();
      t_edges();
      t_buffers();
      finish_test();
   end
endmodule : testbench
